// ===== tb/dds_nco_modulator_core_bench.sv
/*
  Self-checking bench for the synthesis core: loads registers through
  the host model and checks DAC codes at quarter-turn phases.
  Assumes peak sine 511 and offset binary codes as the core defines.
*/
`timescale 1ns/1ps
`default_nettype none
module dds_nco_modulator_core_bench
  import dds_pkg::*;
;
  logic              i_ref_clk = 1'b0;
  logic              i_nrst = 1'b0;
  logic              i_reg_clear = 1'b0;
  logic              i_freq_pick_input = 1'b0;
  logic              i_sleep = 1'b0;
  logic              cs_n, wr_n, sclk, sdata, load;
  logic [DATA_W-1:0] data;
  logic [TC_W-1:0]   code;
  logic [AMP_W-1:0]  o_dac_code, v;
  logic              o_dac_enable;
  int                errors = 0;
  int                total_checks = 0;
  int                cycles = 0;
  int                n0, n1;
  // ************************************************************
  // Clock, timeout and instances
  // ************************************************************
  initial begin
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  // The whole run needs about 800 cycles; 20000 means a hang
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      test_done();
    end
  end
  host_port_model i_host_port_model (.i_ref_clk(i_ref_clk), .o_cs_n(cs_n),
    .o_wr_n(wr_n), .o_data(data), .o_sclk(sclk), .o_sdata(sdata),
    .o_load(load), .o_transfer_code(code));
  dds_nco_modulator_core i_dds_nco_modulator_core (.i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst), .i_reg_clear(i_reg_clear), .i_cs_n(cs_n),
    .i_wr_n(wr_n), .i_data(data), .i_sclk(sclk), .i_sdata(sdata),
    .i_load(load), .i_transfer_code(code),
    .i_freq_pick_input(i_freq_pick_input), .i_sleep(i_sleep),
    .o_dac_code(o_dac_code), .o_dac_enable(o_dac_enable));
  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [AMP_W-1:0] got, exp, input string m);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask : chk
  // Sample just after the edge so that edge's updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask : tick
  task automatic do_reset();
    @(posedge i_ref_clk);
    i_nrst <= 1'b0;
    repeat (16) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    tick(8);
  endtask : do_reset
  // Frequency pick and sleep pins, changed just after an edge
  task automatic set_pins(input logic pick, input logic slp);
    @(posedge i_ref_clk);
    i_freq_pick_input <= pick;
    i_sleep           <= slp;
  endtask : set_pins
  // Narrow writes carry junk in the upper byte, which must be ignored
  task automatic load_par(input logic [31:0] w, input logic [TC_W-1:0] c,
                          input bit wide);
    if (wide) begin
      i_host_port_model.par_write(w[31:16]);
      i_host_port_model.par_write(w[15:0]);
    end else begin
      for (int i = 3; i >= 0; i--)
        i_host_port_model.par_write({8'ha5, w[i*8+:8]});
    end
    i_host_port_model.transfer(c);
    tick(16);
  endtask : load_par
  // Eight samples against a four-step rotation, aligned on the first two
  task automatic check_seq(input logic [AMP_W-1:0] e [4]);
    logic [AMP_W-1:0] s [8];
    int k;
    k = 0;
    for (int i = 0; i < 8; i++) begin
      tick(1);
      s[i] = o_dac_code;
    end
    for (int j = 0; j < 4; j++)
      if (s[0] === e[j] && s[1] === e[(j+1)%4]) k = j;
    for (int i = 0; i < 8; i++) chk(s[i], e[(i+k)%4], "sequence");
  endtask : check_seq
  // Edges from the start of a transfer until the DAC code moves
  task automatic lat(input logic [TC_W-1:0] c, output int n);
    logic [AMP_W-1:0] u;
    #1;
    u = o_dac_code;
    n = 0;
    fork
      i_host_port_model.transfer(c);
      while (o_dac_code === u && n < 40) begin
        tick(1);
        n++;
      end
    join
  endtask : lat
  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    do_reset();
    chk(o_dac_code, 10'h200, "reset code");
    chk({9'h0, o_dac_enable}, 10'h001, "awake after reset");
    $display("test reset done");
    load_par(32'h0000_0400, 4'ha, 1'b0);
    load_par(32'h0000_0001, 4'h0, 1'b0);
    set_pins(1'b1, 1'b0);
    load_par(32'h8000_0000, 4'h9, 1'b1);
    check_seq('{10'h3ff, 10'h001, 10'h3ff, 10'h001});
    load_par(32'h4000_0000, 4'h8, 1'b1);
    set_pins(1'b0, 1'b0);
    tick(16);
    check_seq('{10'h3ff, 10'h200, 10'h001, 10'h200});
    $display("test frequency done");
    i_host_port_model.ser_write(32'h0000_0000);
    i_host_port_model.transfer(4'hc);
    tick(16);
    v = o_dac_code;
    tick(8);
    chk(o_dac_code, v, "serial zero step holds phase");
    i_host_port_model.transfer(4'h4);
    tick(16);
    chk({9'h0, o_dac_enable}, 10'h001, "unused code inert");
    chk(o_dac_code, v, "unused code keeps output");
    $display("test serial done");
    do_reset();
    load_par(32'h0000_0005, 4'h0, 1'b0);
    load_par(32'h0000_0100, 4'hb, 1'b1);
    chk(o_dac_code, 10'h2ff, "half I at phase zero");
    load_par(32'h0004_0000, 4'hb, 1'b1);
    chk(o_dac_code, 10'h200, "half Q at phase zero");
    load_par(32'h0000_0400, 4'ha, 1'b1);
    chk(o_dac_code, 10'h2ff, "half Q at quarter turn");
    load_par(32'h0008_0000, 4'hb, 1'b1);
    chk(o_dac_code, 10'h001, "minus one Q");
    load_par(32'h0000_0001, 4'h0, 1'b1);
    chk(o_dac_code, 10'h3ff, "multipliers bypassed");
    $display("test amplitude done");
    i_host_port_model.par_write(16'h0000);
    i_host_port_model.par_write(16'h0000);
    lat(4'ha, n0);
    load_par(32'h0000_0009, 4'h0, 1'b1);
    i_host_port_model.par_write(16'h0000);
    i_host_port_model.par_write(16'h0400);
    lat(4'ha, n1);
    chk(10'(n0 - n1), 10'(SYNC_STAGES), "synchroniser depth");
    chk(o_dac_code, 10'h3ff, "bypassed offset load");
    $display("test sync done");
    load_par(32'h0000_000b, 4'h0, 1'b1);
    chk({9'h0, o_dac_enable}, 10'h000, "sleep bit");
    load_par(32'h0000_0009, 4'h0, 1'b1);
    chk({9'h0, o_dac_enable}, 10'h001, "wake");
    set_pins(1'b0, 1'b1);
    tick(3);
    chk({9'h0, o_dac_enable}, 10'h000, "sleep pin");
    set_pins(1'b0, 1'b0);
    $display("test sleep done");
    @(posedge i_ref_clk) i_reg_clear <= 1'b1;
    @(posedge i_ref_clk) i_reg_clear <= 1'b0;
    tick(16);
    chk(o_dac_code, 10'h200, "clear zeroes offset");
    chk({9'h0, o_dac_enable}, 10'h001, "awake after clear");
    // Phase still zero here; upper serial bits must not reach the offset
    i_host_port_model.ser_write(32'hffff_fc00);
    i_host_port_model.transfer(4'he);
    tick(16);
    chk(o_dac_code, 10'h001, "serial offset load");
    $display("test clear done");
    test_done();
  end
endmodule : dds_nco_modulator_core_bench
`default_nettype wire

// ===== tb/host_port_model.sv
/*
  Host side model: writes the parallel and serial assembly ports and
  raises transfers, one clean request at a time.
  Assumes the core samples all pins on the rising edge of i_ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module host_port_model
  import dds_pkg::*;
(
  // Clock
  input  wire logic              i_ref_clk,
  // Parallel port
  output logic                   o_cs_n,
  output logic                   o_wr_n,
  output logic [DATA_W-1:0]      o_data,
  // Serial port
  output logic                   o_sclk,
  output logic                   o_sdata,
  // Transfer control
  output logic                   o_load,
  output logic [TC_W-1:0]        o_transfer_code
);
  // ************************************************************
  // Idle levels
  // ************************************************************
  initial begin
    o_cs_n = 1'b1;
    o_wr_n = 1'b1;
    o_data = 16'h0000;
    o_sclk = 1'b0;
    o_sdata = 1'b0;
    o_load = 1'b0;
    o_transfer_code = 4'h0;
  end
  // One write: strobe low one cycle, then high one cycle; released data
  // is inverted so a stale bus never looks valid
  task automatic par_write(input logic [DATA_W-1:0] d);
    @(posedge i_ref_clk);
    o_cs_n <= 1'b0;
    o_wr_n <= 1'b0;
    o_data <= d;
    @(posedge i_ref_clk);
    o_cs_n <= 1'b1;
    o_wr_n <= 1'b1;
    o_data <= ~d;
  endtask : par_write
  // Serial word, MSB first; the serial clock stands still between words
  task automatic ser_write(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      @(posedge i_ref_clk);
      o_sclk <= 1'b1;
      o_sdata <= w[i];
      @(posedge i_ref_clk);
      o_sclk <= 1'b0;
      o_sdata <= ~w[i];
    end
  endtask : ser_write
  // Code set a cycle ahead of load and held until the synchroniser is done
  task automatic transfer(input logic [TC_W-1:0] c);
    @(posedge i_ref_clk);
    o_transfer_code <= c;
    @(posedge i_ref_clk);
    o_load <= 1'b1;
    @(posedge i_ref_clk);
    o_load <= 1'b0;
    repeat (SYNC_STAGES + 2) @(posedge i_ref_clk);
    o_transfer_code <= ~c;
  endtask : transfer
endmodule : host_port_model
`default_nettype wire

// ===== verilog/dds_nco_modulator_core.sv
/*
  Synthesis core: parallel and serial assembly registers, transfer into
  control and modulation registers, control synchroniser, 32-bit phase
  accumulator, phase offset, sine/cosine generation, I/Q amplitude
  multipliers and the 10-bit DAC code.
  Assumes all pins are synchronous to i_ref_clk; the DAC itself is outside.
*/
// Operation
// - Narrow bus: ignore upper byte, shift assembly left eight per write.
// - Wide bus: shift assembly left sixteen per write, two writes fill it.
// - Sleep bit stops internal clocking and switches DAC current off.
// - Modulation disabled: sine value goes straight to the DAC code.
// - Modulation enabled: sine and cosine pass through I/Q multipliers.
// - Sync bypass clear: select, load, code pass a four stage pipeline.
// - Sync bypass set: select, load, code are used directly.
// - Control register loads only from the parallel assembly register.
// - 32-bit accumulator adds chosen step, wraps modulo two to 32.
// - Select low uses first step word, high uses second.
// - Changing step word never reloads the accumulator.
// - Phase offset adds to the accumulator's top bits.
// - Tables use only the top twelve phase bits.
// - Cosine scaled by amplitude bits 9..0, sine by bits 19..10.
// - I plus Q sum wraps in ten bits, never saturates.
// - A ten-bit DAC code is delivered every cycle while awake; asleep it holds.
// - Amplitude fields are ten-bit two's complement fractions.
// - Register clear input zeroes control and modulation registers.
`timescale 1ns/1ps
`default_nettype none
module dds_nco_modulator_core
  import dds_pkg::*;
(
  // Clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_nrst,
  input  wire logic              i_reg_clear,
  // Parallel write port
  input  wire logic              i_cs_n,
  input  wire logic              i_wr_n,
  input  wire logic [DATA_W-1:0] i_data,
  // Serial write port
  input  wire logic              i_sclk,
  input  wire logic              i_sdata,
  // Transfer and frequency control
  input  wire logic              i_load,
  input  wire logic [TC_W-1:0]   i_transfer_code,
  input  wire logic              i_freq_pick_input,
  input  wire logic              i_sleep,
  // DAC side
  output logic [AMP_W-1:0]       o_dac_code,
  output logic                   o_dac_enable
);

  // ************************************************************
  // Sine of a 12-bit phase, 10-bit two's complement
  // ************************************************************
  // Parabolic quarter wave; cheaper than a 4096 entry table
  function automatic logic [AMP_W-1:0] sine_of(input logic [11:0] ph);
    logic [9:0]  x;
    logic [21:0] sq;
    logic [9:0]  mag;
    x   = ph[10] ? ~ph[9:0] : ph[9:0];
    sq  = {12'h000, x} * (22'h0007ff - {12'h000, x});
    mag = {1'b0, sq[19:11]};
    return ph[11] ? (10'h000 - mag) : mag;
  endfunction : sine_of

  // ************************************************************
  // Registers
  // ************************************************************
  logic [ACC_W-1:0]   par_reg;
  logic [ACC_W-1:0]   ser_reg;
  logic               strobe_d_reg;
  logic               sclk_d_reg;
  logic               load_d_reg;
  logic [CTRL_W-1:0]  control_config_reg;
  logic [ACC_W-1:0]   step_word_a_reg;
  logic [ACC_W-1:0]   step_word_b_reg;
  logic [PHASE_W-1:0] phase_offset_word_reg;
  logic [IQ_W-1:0]    iq_amplitude_word_reg;
  logic [CTL_W-1:0]   sync_reg [SYNC_STAGES];
  logic [ACC_W-1:0]   acc_reg;
  logic [PHASE_W-1:0] phase_reg;
  logic [AMP_W-1:0]   sin_reg;
  logic [AMP_W-1:0]   cos_reg;
  logic [AMP_W-1:0]   prod_i_reg;
  logic [AMP_W-1:0]   prod_q_reg;
  logic [AMP_W-1:0]   sin_d_reg;

  // ************************************************************
  // Decode and selection
  // ************************************************************
  wire logic             bus_width_bit = control_config_reg[BUS_WIDTH_BIT];
  wire logic             sleep_bit     = control_config_reg[SLEEP_BIT];
  wire logic             amplitude_mod_enable_bit =
                           control_config_reg[AMP_MOD_EN_BIT];
  wire logic             sync_bypass_bit = control_config_reg[SYNC_BYPASS_BIT];
  wire logic             strobe   = ~i_cs_n & ~i_wr_n;
  wire logic             wr_start = strobe & ~strobe_d_reg;
  wire logic             sclk_rise = i_sclk & ~sclk_d_reg;
  wire logic [CTL_W-1:0] ctl_raw  = {i_freq_pick_input, i_load,
                                     i_transfer_code};
  // Bypass trades metastability safety for four cycles less latency
  wire logic [CTL_W-1:0] ctl_eff  = sync_bypass_bit ? ctl_raw
                                    : sync_reg[SYNC_STAGES-1];
  wire logic             sel_eff  = ctl_eff[CTL_W-1];
  wire logic             load_eff = ctl_eff[TC_W];
  wire logic [TC_W-1:0]  tc_eff   = ctl_eff[TC_W-1:0];
  wire logic             load_start = load_eff & ~load_d_reg;
  wire logic [1:0]       tc_src   = tc_eff[3:2];
  wire logic [1:0]       tc_dst   = tc_eff[1:0];
  // Only the parallel source may reach the control register
  wire logic             ld_ctrl  = load_start & (tc_src == TC_SRC_CTRL);
  wire logic             ld_mod   = load_start &
                                    (tc_src == TC_SRC_PAR ||
                                     tc_src == TC_SRC_SER);
  wire logic [ACC_W-1:0] mod_src  = (tc_src == TC_SRC_SER) ? ser_reg : par_reg;
  // Upper data byte never enters in narrow mode
  wire logic [ACC_W-1:0] par_next = bus_width_bit
    ? {par_reg[ACC_W-DATA_W-1:0], i_data}
    : {par_reg[ACC_W-BYTE_W-1:0], i_data[BYTE_W-1:0]};
  wire logic             asleep   = sleep_bit | i_sleep;
  wire logic             run      = ~asleep;
  // Step word chosen per cycle; accumulator is never reloaded
  wire logic [ACC_W-1:0] step = sel_eff ? step_word_b_reg
                                        : step_word_a_reg;
  wire logic [PHASE_W-1:0] phase_next =
    acc_reg[ACC_W-1:ACC_W-PHASE_W] + phase_offset_word_reg;
  wire logic signed [AMP_W-1:0] amp_i = iq_amplitude_word_reg[9:0];
  wire logic signed [AMP_W-1:0] amp_q = iq_amplitude_word_reg[19:10];
  // Signed fraction products, scaled back to ten bits
  wire logic signed [2*AMP_W-1:0] mul_i =
    (2*AMP_W)'($signed(cos_reg)) * (2*AMP_W)'(amp_i);
  wire logic signed [2*AMP_W-1:0] mul_q =
    (2*AMP_W)'($signed(sin_reg)) * (2*AMP_W)'(amp_q);
  // Ten-bit sum rolls over; range is the host's job
  wire logic [AMP_W-1:0] iq_sum   = prod_i_reg + prod_q_reg;
  wire logic [AMP_W-1:0] code_two = amplitude_mod_enable_bit
                                    ? iq_sum : sin_d_reg;

  // ************************************************************
  // Port edge detectors and assembly registers
  // ************************************************************
  // Shift on the first cycle of each write strobe
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      par_reg      <= STEP_RST;
      strobe_d_reg <= 1'b0;
    end else begin
      strobe_d_reg <= strobe;
      if (wr_start) begin
        par_reg <= par_next;
      end
    end
  end

  // Serial data enters MSB first on each clock rise
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ser_reg    <= STEP_RST;
      sclk_d_reg <= 1'b0;
    end else begin
      sclk_d_reg <= i_sclk;
      if (sclk_rise) begin
        ser_reg <= {ser_reg[ACC_W-2:0], i_sdata};
      end
    end
  end

  // ************************************************************
  // Control synchroniser
  // ************************************************************
  // Runs even asleep so a wake-up transfer is not lost
  generate
    for (genvar s = 0; s < SYNC_STAGES; s++) begin : g_sync
      always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          sync_reg[s] <= '0;
        end else if (s == 0) begin
          sync_reg[s] <= ctl_raw;
        end else begin
          sync_reg[s] <= sync_reg[s-1];
        end
      end
    end
  endgenerate

  // ************************************************************
  // Transfers into control and modulation registers
  // ************************************************************
  // One transfer per load rise; the clear input wins
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      load_d_reg            <= 1'b0;
      control_config_reg    <= CTRL_RST;
      step_word_a_reg       <= STEP_RST;
      step_word_b_reg       <= STEP_RST;
      phase_offset_word_reg <= OFFSET_RST;
      iq_amplitude_word_reg <= IQ_RST;
    end else begin
      load_d_reg <= load_eff;
      if (i_reg_clear) begin
        control_config_reg    <= CTRL_RST;
        step_word_a_reg       <= STEP_RST;
        step_word_b_reg       <= STEP_RST;
        phase_offset_word_reg <= OFFSET_RST;
        iq_amplitude_word_reg <= IQ_RST;
      end else if (ld_ctrl) begin
        control_config_reg <= par_reg[CTRL_W-1:0];
      end else if (ld_mod) begin
        case (tc_dst)
          TC_DST_STEP_A: step_word_a_reg       <= mod_src;
          TC_DST_STEP_B: step_word_b_reg       <= mod_src;
          TC_DST_OFFSET: phase_offset_word_reg <= mod_src[PHASE_W-1:0];
          TC_DST_IQ:     iq_amplitude_word_reg <= mod_src[IQ_W-1:0];
          default:       step_word_a_reg       <= step_word_a_reg;
        endcase
      end
    end
  end

  // ************************************************************
  // Phase accumulator and phase offset
  // ************************************************************
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      acc_reg   <= STEP_RST;
      phase_reg <= OFFSET_RST;
    end else if (run) begin
      acc_reg   <= acc_reg + step;
      phase_reg <= phase_next;
    end
  end

  // ************************************************************
  // Tables, multipliers and DAC code
  // ************************************************************
  // Stages hold while asleep, as if their clock stopped
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sin_reg      <= '0;
      cos_reg      <= '0;
      prod_i_reg   <= '0;
      prod_q_reg   <= '0;
      sin_d_reg    <= '0;
      o_dac_code   <= DAC_MSB_FLIP;
      o_dac_enable <= 1'b0;
    end else begin
      o_dac_enable <= run;
      if (run) begin
        sin_reg    <= sine_of(phase_reg);
        cos_reg    <= sine_of(phase_reg + QUARTER_TURN);
        prod_i_reg <= mul_i[FRAC_LSB+AMP_W-1:FRAC_LSB];
        prod_q_reg <= mul_q[FRAC_LSB+AMP_W-1:FRAC_LSB];
        sin_d_reg  <= sin_reg;
        o_dac_code <= code_two ^ DAC_MSB_FLIP;
      end
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);

  property p_shift8;
    wr_start && !bus_width_bit |=>
      par_reg == {$past(par_reg[23:0]), $past(i_data[7:0])};
  endproperty
  a_shift8: assert property (p_shift8)
    else $error("narrow write did not shift by eight");
  property p_shift16;
    wr_start && bus_width_bit |=>
      par_reg == {$past(par_reg[15:0]), $past(i_data)};
  endproperty
  a_shift16: assert property (p_shift16)
    else $error("wide write did not shift by sixteen");
  property p_sleep_hold;
    asleep |=> acc_reg == $past(acc_reg) && !o_dac_enable;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold)
    else $error("accumulator moved or DAC on while asleep");
  property p_am_off;
    run && !amplitude_mod_enable_bit |=>
      o_dac_code == ($past(sin_d_reg) ^ DAC_MSB_FLIP);
  endproperty
  a_am_off: assert property (p_am_off)
    else $error("bypass path did not carry sine");
  property p_am_sum;
    run && amplitude_mod_enable_bit |=>
      o_dac_code == (AMP_W'($past(prod_i_reg) + $past(prod_q_reg))
                     ^ DAC_MSB_FLIP);
  endproperty
  a_am_sum: assert property (p_am_sum)
    else $error("modulated sum wrong or saturated");
  property p_bypass;
    sync_bypass_bit |-> load_eff == i_load && sel_eff == i_freq_pick_input;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass did not use raw controls");
  property p_sync4;
    !sync_bypass_bit ##0 $past(i_nrst, 4) |->
      sel_eff == $past(i_freq_pick_input, 4) && load_eff == $past(i_load, 4);
  endproperty
  a_sync4: assert property (p_sync4)
    else $error("controls not delayed by four stages");

  property p_ctrl_par_only;
    load_start && tc_src == TC_SRC_SER && !i_reg_clear |=>
      $stable(control_config_reg);
  endproperty
  a_ctrl_par_only: assert property (p_ctrl_par_only)
    else $error("serial transfer changed control register");

  property p_step_a;
    run && !sel_eff |=> acc_reg == ACC_W'($past(acc_reg) +
                                          $past(step_word_a_reg));
  endproperty
  a_step_a: assert property (p_step_a)
    else $error("accumulator did not add first step word");

  property p_step_b;
    run && sel_eff |=> acc_reg == ACC_W'($past(acc_reg) +
                                         $past(step_word_b_reg));
  endproperty
  a_step_b: assert property (p_step_b)
    else $error("accumulator did not add second step word");

  property p_clear;
    i_reg_clear |=> control_config_reg == CTRL_RST &&
      phase_offset_word_reg == OFFSET_RST && iq_amplitude_word_reg == IQ_RST;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear input left a register set");

endmodule : dds_nco_modulator_core
`default_nettype wire

// ===== verilog/dds_pkg.sv
/*
  Shared constants of the synthesis core: widths, control bit positions,
  transfer code values and pipeline depths.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package dds_pkg;
  // ************************************************************
  // Widths
  // ************************************************************
  localparam int ACC_W    = 32;
  localparam int PHASE_W  = 12;
  localparam int IQ_W     = 20;
  localparam int AMP_W    = 10;
  localparam int CTRL_W   = 4;
  localparam int DATA_W   = 16;
  localparam int BYTE_W   = 8;
  localparam int TC_W     = 4;
  // ************************************************************
  // Control field positions and reset values
  // ************************************************************
  localparam int BUS_WIDTH_BIT     = 0;
  localparam int SLEEP_BIT         = 1;
  localparam int AMP_MOD_EN_BIT    = 2;
  localparam int SYNC_BYPASS_BIT   = 3;
  localparam logic [3:0]  CTRL_RST   = 4'h0;
  localparam logic [31:0] STEP_RST   = 32'h0000_0000;
  localparam logic [11:0] OFFSET_RST = 12'h000;
  localparam logic [19:0] IQ_RST     = 20'h0_0000;
  // ************************************************************
  // Transfer code fields: top two bits pick the source
  // ************************************************************
  localparam logic [1:0] TC_SRC_CTRL   = 2'h0;
  localparam logic [1:0] TC_SRC_PAR    = 2'h2;
  localparam logic [1:0] TC_SRC_SER    = 2'h3;
  localparam logic [1:0] TC_DST_STEP_A = 2'h0;
  localparam logic [1:0] TC_DST_STEP_B = 2'h1;
  localparam logic [1:0] TC_DST_OFFSET = 2'h2;
  localparam logic [1:0] TC_DST_IQ     = 2'h3;
  // ************************************************************
  // Timing and datapath constants
  // ************************************************************
  localparam int SYNC_STAGES = 4;
  localparam int CTL_W       = 1 + 1 + TC_W; // select, load, code
  localparam int FRAC_LSB    = 9;            // amplitude is value/512
  localparam logic [11:0] QUARTER_TURN = 12'h400;
  localparam logic [9:0]  DAC_MSB_FLIP = 10'h200;
endpackage : dds_pkg
`default_nettype wire
